// ---- verilog/asr_top.sv ----
// slave serial readout port of an 18-bit converter
`timescale 1ns/1ps
`default_nettype none
module asr_top #(
  parameter int unsigned WORD_W      = asr_pkg::WORD_W,
  parameter int unsigned FIFO_DEPTH  = asr_pkg::FIFO_DEPTH,
  parameter int unsigned CONV_CYCLES = asr_pkg::CONV_CYCLES
) (
  input  wire logic              sys_clk,               // 50 MHz clock
  input  wire logic              rst_n,                 // async reset, low
  input  wire logic              ce,                    // clock enable
  input  wire logic              convert_start_n,       // start pin, low
  input  wire logic              cs_n,                  // device select
  input  wire logic              rd_n,                  // read enable
  input  wire logic              sclk,                  // external clock
  input  wire logic              clock_source_select,   // high: external
  input  wire logic              interface_select_bit0, // mode bit 0
  input  wire logic              interface_select_bit1, // mode bit 1
  input  wire logic              read_during_conv,      // readout mode
  input  wire logic              readmode_or_chain_in,  // chain data in
  input  wire logic [WORD_W-1:0] result_data,           // core result
  input  wire logic              result_valid,          // result offered
  output logic                   result_ready,          // buffer room
  output logic                   serial_result_out,     // serial data
  output logic                   serial_result_oe_n,    // drive when low
  output logic                   busy,                  // converting
  output logic                   readout_overrun_flag   // error pulse
);
  localparam logic [asr_pkg::CONV_CNT_W-1:0] CONV_LAST =
    asr_pkg::CONV_CNT_W'(CONV_CYCLES - 1);
  localparam logic [asr_pkg::BIT_CNT_W-1:0] BIT_LAST =
    asr_pkg::BIT_CNT_W'(WORD_W);

  // registered state of the port, apart from reset sync and buffer
  typedef struct packed {
    logic                              cnv_m;   // sync stage one
    logic                              cnv_s;   // sync stage two
    logic                              cnv_p;   // previous synced
    logic                              cs_m;
    logic                              cs_s;
    logic                              rd_m;
    logic                              rd_s;
    logic                              sclk_m;
    logic                              sclk_s;
    logic                              sclk_p;
    logic                              ext_m;
    logic                              ext_s;
    logic                              ser0_m;
    logic                              ser0_s;
    logic                              ser1_m;
    logic                              ser1_s;
    logic                              rdc_m;
    logic                              rdc_s;
    logic                              chain_m;
    logic                              chain_s;
    logic                              chain_bit; // latched chain input
    asr_pkg::asr_state_t               state;
    logic [asr_pkg::CONV_CNT_W-1:0]    conv_cnt;
    logic [WORD_W-1:0]                 shift;
    logic [asr_pkg::BIT_CNT_W-1:0]     bit_cnt;
    logic                              busy;
    logic                              sdo;
    logic                              oe_n;
    logic                              err;
  } asr_state_s_t;

  asr_state_s_t s_q;
  asr_state_s_t s_d;
  logic         rst_m_n;
  logic         rst_s_n;
  logic [WORD_W-1:0] fifo_data;
  logic         fifo_valid;
  logic         fifo_pop;

  // serial port usable: serial mode and both strobes low
  function automatic logic port_open(input logic ser0, input logic ser1,
                                     input logic cs, input logic rd);
    port_open = ser0 && ser1 && !cs && !rd;
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_n <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      rst_m_n <= 1'b1;
      rst_s_n <= rst_m_n;
    end
  end

  // buffer between converter core and output shift register
  asr_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (sys_clk),
    .rst_n     (rst_s_n),
    .ce        (ce),
    .in_data   (result_data),
    .in_valid  (result_valid),
    .in_ready  (result_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign fifo_pop = (s_q.state == asr_pkg::ASR_FETCH) && fifo_valid;

  // next-state logic for sync, sequencer and shifter
  always_comb begin
    logic open;
    logic ext_clk;
    logic rise;
    logic fall;
    logic chain_used;
    open       = 1'b0;
    ext_clk    = 1'b0;
    rise       = 1'b0;
    fall       = 1'b0;
    chain_used = 1'b0;
    s_d        = s_q;

    // pin synchronisers, first stage read only by second
    s_d.cnv_m   = convert_start_n;
    s_d.cnv_s   = s_q.cnv_m;
    s_d.cnv_p   = s_q.cnv_s;
    s_d.cs_m    = cs_n;
    s_d.cs_s    = s_q.cs_m;
    s_d.rd_m    = rd_n;
    s_d.rd_s    = s_q.rd_m;
    s_d.sclk_m  = sclk;
    s_d.sclk_s  = s_q.sclk_m;
    s_d.sclk_p  = s_q.sclk_s;
    s_d.ext_m   = clock_source_select;
    s_d.ext_s   = s_q.ext_m;
    s_d.ser0_m  = interface_select_bit0;
    s_d.ser0_s  = s_q.ser0_m;
    s_d.ser1_m  = interface_select_bit1;
    s_d.ser1_s  = s_q.ser1_m;
    s_d.rdc_m   = read_during_conv;
    s_d.rdc_s   = s_q.rdc_m;
    s_d.chain_m = readmode_or_chain_in;
    s_d.chain_s = s_q.chain_m;
    s_d.err     = 1'b0;

    open    = port_open(s_q.ser0_s, s_q.ser1_s, s_q.cs_s, s_q.rd_s);
    ext_clk = s_q.ext_s;
    // edges found from levels only, so any idle level or gating works
    rise = open && ext_clk && s_q.sclk_s && !s_q.sclk_p;
    fall = open && ext_clk && !s_q.sclk_s && s_q.sclk_p;
    chain_used = !s_q.rdc_s;

    // conversion sequencer, blind to the strobes once running
    unique case (s_q.state)
      asr_pkg::ASR_IDLE: begin
        if (s_q.cnv_p && !s_q.cnv_s) begin
          s_d.state    = asr_pkg::ASR_CONVERT;
          s_d.busy     = 1'b1;
          s_d.conv_cnt = asr_pkg::CONV_CNT_ZERO;
        end
      end
      asr_pkg::ASR_CONVERT: begin
        if (s_q.conv_cnt == CONV_LAST) begin
          s_d.state = asr_pkg::ASR_FETCH;
        end else begin
          s_d.conv_cnt = s_q.conv_cnt + asr_pkg::CONV_CNT_ONE;
        end
      end
      asr_pkg::ASR_FETCH: begin
        // busy stays high until the core's result is in the buffer
        if (fifo_valid) begin
          s_d.state = asr_pkg::ASR_IDLE;
          s_d.busy  = 1'b0;
        end
      end
    endcase

    // chain input latched on rising edge, opposite the launch edge
    if (rise && chain_used) begin
      s_d.chain_bit = s_q.chain_s;
    end

    // launch next bit on each falling edge, in read-during mode only until bit_cnt reaches BIT_LAST; shifting goes on in busy
    if (fall && (s_q.bit_cnt != BIT_LAST || chain_used)) begin
      // upstream word follows own LSB; zero fill without chain
      s_d.shift = {s_q.shift[WORD_W-2:0],
                   chain_used ? s_q.chain_bit : 1'b0};
      if (s_q.bit_cnt != BIT_LAST) begin
        s_d.bit_cnt = s_q.bit_cnt + asr_pkg::BIT_CNT_ONE;
      end
    end

    // read-during mode: a started but unfinished read is an error
    if (fifo_pop && s_q.rdc_s && s_q.bit_cnt != asr_pkg::BIT_CNT_ZERO
        && s_q.bit_cnt != BIT_LAST) begin
      s_d.err = 1'b1;
    end

    // new result loaded at busy fall, readout restarts at MSB
    if (fifo_pop) begin
      s_d.shift   = fifo_data;
      s_d.bit_cnt = asr_pkg::BIT_CNT_ZERO;
    end

    // output pin: data MSB of shifter, released unless port open
    s_d.sdo  = s_d.shift[WORD_W-1];
    s_d.oe_n = !port_open(s_d.ser0_s, s_d.ser1_s, s_d.cs_s, s_d.rd_s);
  end

  // single state register, frozen while ce is low
  always_ff @(posedge sys_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      s_q         <= '0;
      s_q.cnv_m   <= 1'b1;
      s_q.cnv_s   <= 1'b1;
      s_q.cnv_p   <= 1'b1;
      s_q.cs_m    <= 1'b1;
      s_q.cs_s    <= 1'b1;
      s_q.rd_m    <= 1'b1;
      s_q.rd_s    <= 1'b1;
      s_q.state   <= asr_pkg::ASR_IDLE;
      s_q.shift   <= asr_pkg::RESULT_RST;
      s_q.oe_n    <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign serial_result_out    = s_q.sdo;
  assign serial_result_oe_n   = s_q.oe_n;
  assign busy                 = s_q.busy;
  assign readout_overrun_flag = s_q.err;
endmodule // asr_top
`default_nettype wire

// ---- verilog/asr_pkg.sv ----
// constants and types for the slave serial readout block
`default_nettype none
package asr_pkg;
  localparam int unsigned WORD_W       = 18;   // result width, bits
  localparam int unsigned FIFO_DEPTH   = 8;    // result buffer depth
  localparam int unsigned CLK_PERIOD_NS = 20;  // sys_clk period
  localparam int unsigned CONV_TIME_NS = 7000; // conversion time, least
  // least time rounds up to whole cycles
  localparam int unsigned CONV_CYCLES =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_CNT_W   = 16;   // conversion counter width
  localparam int unsigned BIT_CNT_W    = 5;    // readout bit counter width
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 5'h00;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE  = 5'h01;
  localparam logic [CONV_CNT_W-1:0] CONV_CNT_ZERO = 16'h0000;
  localparam logic [CONV_CNT_W-1:0] CONV_CNT_ONE  = 16'h0001;
  localparam logic [WORD_W-1:0] RESULT_RST = 18'h00000;

  // conversion sequencer states
  typedef enum logic [1:0] {
    ASR_IDLE,
    ASR_CONVERT,
    ASR_FETCH
  } asr_state_t;
endpackage
`default_nettype wire

// ---- verilog/asr_fifo.sv ----
// result buffer fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module asr_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,       // system clock
  input  wire logic             rst_n,     // synchronised reset, low
  input  wire logic             ce,        // clock enable
  input  wire logic [WIDTH-1:0] in_data,   // write data
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // room available
  output logic      [WIDTH-1:0] out_data,  // read data
  output logic                  out_valid, // data available
  input  wire logic             out_ready  // read accept
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } asr_fifo_state_t;

  asr_fifo_state_t s_q;
  asr_fifo_state_t s_d;
  logic            push;
  logic            pop;

  // flags straight from the registered count
  assign in_ready  = (s_q.count != CNT_FULL);
  assign out_valid = (s_q.count != '0);
  assign out_data  = s_q.mem[s_q.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and storage update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr_ptr] = in_data;
      s_d.wr_ptr = (s_q.wr_ptr == PTR_LAST) ? '0 : s_q.wr_ptr + PTR_ONE;
    end
    if (pop) begin
      s_d.rd_ptr = (s_q.rd_ptr == PTR_LAST) ? '0 : s_q.rd_ptr + PTR_ONE;
    end
    if (push && !pop) begin
      s_d.count = s_q.count + CNT_ONE;
    end else if (pop && !push) begin
      s_d.count = s_q.count - CNT_ONE;
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule // asr_fifo
`default_nettype wire

// ---- tb/asr_top_properties.sv ----
// concurrent checks on the serial readout block ports
`timescale 1ns/1ps
`default_nettype none
module asr_top_properties #(
  parameter int unsigned CONV_CYCLES = 350 // conversion length, cycles
) (
  input wire logic sys_clk,               // system clock
  input wire logic rst_n,                 // async reset, low
  input wire logic convert_start_n,       // start pin
  input wire logic cs_n,                  // device select
  input wire logic rd_n,                  // read enable
  input wire logic sclk,                  // external clock
  input wire logic clock_source_select,   // external clock chosen
  input wire logic interface_select_bit0, // mode bit 0
  input wire logic interface_select_bit1, // mode bit 1
  input wire logic read_during_conv,      // readout mode
  input wire logic serial_result_out,     // serial data
  input wire logic serial_result_oe_n,    // drive when low
  input wire logic busy,                  // converting
  input wire logic readout_overrun_flag   // error pulse
);
  logic [15:0] busy_cnt_q; // cycles busy has stood
  logic [2:0]  bz_q;       // recent busy falls
  logic [5:0]  sk_q;       // recent sclk falls
  logic [3:0]  op_q;       // recent open port
  logic [1:0]  pin_q;      // sclk and busy last cycle
  // histories of the causes of a serial line change
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_q <= 16'h0000;
      bz_q       <= 3'h0;
      sk_q       <= 6'h00;
      op_q       <= 4'h0;
      pin_q      <= 2'h0;
    end else begin
      busy_cnt_q <= busy ? busy_cnt_q + 16'h0001 : 16'h0000;
      pin_q      <= {sclk, busy};
      bz_q       <= {bz_q[1:0], pin_q[0] & ~busy};
      sk_q       <= {sk_q[4:0], pin_q[1] & ~sclk};
      op_q       <= {op_q[2:0], ~cs_n & ~rd_n & clock_source_select};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  oe_release_a: assert property (
    (cs_n || rd_n)[*5] |-> serial_result_oe_n)
    else $error("output driven while port closed");
  oe_open_a: assert property (
    (!cs_n && !rd_n && interface_select_bit0
    && interface_select_bit1)[*5] |-> !serial_result_oe_n)
    else $error("output not driven while port open");
  busy_start_a: assert property (
    $fell(convert_start_n) && !busy |-> ##[3:5] busy)
    else $error("conversion did not start");
  busy_hold_a: assert property (
    $fell(busy) |-> busy_cnt_q > CONV_CYCLES)
    else $error("busy fell too early");
  flag_pulse_a: assert property (
    readout_overrun_flag |=> !readout_overrun_flag)
    else $error("error flag longer than one cycle");
  flag_mode_a: assert property (
    readout_overrun_flag |-> read_during_conv && !busy)
    else $error("error flag out of place");
  sdo_cause_a: assert property (
    $changed(serial_result_out) |-> $fell(busy) || (|bz_q) || (|sk_q))
    else $error("serial line moved by itself");
  closed_shift_a: assert property (
    $changed(serial_result_out) && !$fell(busy) && !(|bz_q) |-> |op_q)
    else $error("shift while port closed");
endmodule // asr_top_properties
bind asr_top asr_top_properties #(.CONV_CYCLES(CONV_CYCLES)) i_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .convert_start_n(convert_start_n),
  .cs_n(cs_n), .rd_n(rd_n), .sclk(sclk),
  .clock_source_select(clock_source_select),
  .interface_select_bit0(interface_select_bit0),
  .interface_select_bit1(interface_select_bit1),
  .read_during_conv(read_during_conv),
  .serial_result_out(serial_result_out),
  .serial_result_oe_n(serial_result_oe_n), .busy(busy),
  .readout_overrun_flag(readout_overrun_flag));
`default_nettype wire

// ---- tb/asr_host_model.sv ----
// host serial master model: gated clock, capture, chain source
`timescale 1ns/1ps
`default_nettype none
module asr_host_model (
  input  wire logic        clk,     // system clock, for alignment
  input  wire logic        sdo,     // serial data from the port
  input  wire logic        oe_n,    // port drives the wire when low
  input  wire logic [17:0] up_word, // upstream converter word
  output logic             sclk,    // gated clock, idle low
  output logic             chain,   // upstream serial data
  output logic      [35:0] word     // captured bits, newest lowest
);
  logic line;          // level seen on the data wire
  logic last_q = 1'b0; // last bit the port drove
  // a released wire shows the inverse of the last driven bit
  always @(posedge clk) if (!oe_n) last_q <= sdo;
  assign line = oe_n ? ~last_q : sdo;
  initial begin
    sclk  = 1'b0;
    chain = 1'b0;
    word  = '0;
  end
  // one burst: long low phase so the shifted bit settles before the rise
  task automatic xfer(input int n);
    int k;
    @(negedge clk);
    for (k = 0; k < n; k++) begin
      chain = (k < 18) ? up_word[17 - k] : 1'b0;
      #120 sclk = 1'b1;
      word = {word[34:0], line};
      #40 sclk = 1'b0;
    end
  endtask
endmodule // asr_host_model
`default_nettype wire

// ---- tb/asr_top_test.sv ----
// self-checking bench for the slave serial readout block
`timescale 1ns/1ps
`default_nettype none
module asr_top_test;
  localparam int unsigned CC = 200; // shortened conversion
  logic clk = 1'b0, rst_n = 1'b0, cnv_n = 1'b1, cs_n = 1'b0, rd_n = 1'b0;
  logic ext = 1'b1, rdc = 1'b0, vld = 1'b0, rdy, sdo, oe_n, busy, flag;
  logic sclk, chain, ce = 1'b1, ms0 = 1'b1, ms1 = 1'b1;
  logic [17:0] din = 18'h00000, up = 18'h00000;
  logic [35:0] word;
  int bad_count = 0, cmp_count = 0, nflag = 0, i;
  always #10 clk = ~clk;
  always @(posedge clk) if (flag === 1'b1) nflag <= nflag + 1;
  asr_top #(.CONV_CYCLES(CC)) i_dut (.sys_clk(clk), .rst_n(rst_n),
    .ce(ce), .convert_start_n(cnv_n), .cs_n(cs_n), .rd_n(rd_n),
    .sclk(sclk), .clock_source_select(ext), .interface_select_bit0(ms0),
    .interface_select_bit1(ms1), .read_during_conv(rdc),
    .readmode_or_chain_in(chain), .result_data(din), .result_valid(vld),
    .result_ready(rdy), .serial_result_out(sdo), .serial_result_oe_n(oe_n),
    .busy(busy), .readout_overrun_flag(flag));
  asr_host_model i_host (.clk(clk), .sdo(sdo), .oe_n(oe_n), .up_word(up),
    .sclk(sclk), .chain(chain), .word(word));
  function automatic logic [17:0] wv(input int k);
    return 18'h2A5C3 + 18'(k) * 18'h0B6D5;
  endfunction
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait for a busy level
  task automatic wb(input logic lv, input int lim);
    int n;
    n = 0;
    while (busy !== lv) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        bad_count++;
        $display("[FAIL] %0t busy wait ran out", $time);
        end_sim();
      end
    end
  endtask
  // offer one word, held until the buffer takes it
  task automatic push(input logic [17:0] w);
    int n;
    n = 0;
    @(negedge clk);
    din = w;
    vld = 1'b1;
    while (rdy !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 50) begin
        bad_count++;
        $display("[FAIL] %0t buffer wait ran out", $time);
        end_sim();
      end
    end
    @(negedge clk);
    vld = 1'b0;
  endtask
  // start one conversion, optionally waiting for its end
  task automatic conv(input logic fin);
    @(negedge clk);
    cnv_n = 1'b0;
    wb(1'b1, 10);
    @(negedge clk);
    cnv_n = 1'b1;
    if (fin) wb(1'b0, CC + 20);
    repeat (2) @(negedge clk);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    chk({sdo, oe_n, busy, flag, rdy}, 5'b01001);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (i = 0; i < 8; i++) push(wv(i));
    chk(rdy, 1'b0); // buffer full refuses
    up = 18'h1B3C5;
    conv(1'b1);
    i_host.xfer(36);
    chk(word, {wv(0), up});
    up = 18'h00000;
    // close the port two ways or deselect the external clock, clock it, reopen and read whole word
    for (i = 0; i < 3; i++) begin
      conv(1'b1);
      cs_n = (i == 0);
      rd_n = (i == 1);
      ext  = (i != 2);
      repeat (4) @(negedge clk);
      if (i < 2) chk(oe_n, 1'b1);
      i_host.xfer(4);
      repeat (8) @(negedge clk);
      cs_n = 1'b0;
      rd_n = 1'b0;
      ext  = 1'b1;
      repeat (6) @(negedge clk);
      chk(oe_n, 1'b0);
      i_host.xfer(20);
      chk(word[19:0], {wv(i + 1), 2'b00});
    end
    conv(1'b1);
    i_host.xfer(9);
    conv(1'b0);
    i_host.xfer(9);
    chk(word[17:0], wv(4));
    wb(1'b0, CC + 20);
    rdc = 1'b1;
    conv(1'b0);
    i_host.xfer(20);
    chk(word[19:0], {wv(5), 2'b00});
    wb(1'b0, CC + 20);
    repeat (3) @(negedge clk);
    chk(nflag, 0);
    conv(1'b0);
    i_host.xfer(5);
    wb(1'b0, CC + 20);
    repeat (3) @(negedge clk);
    chk(nflag, 1);
    rdc = 1'b0;
    conv(1'b0);
    repeat (CC + 40) @(negedge clk);
    chk(busy, 1'b1);
    push(wv(8));
    wb(1'b0, 20);
    repeat (2) @(negedge clk);
    i_host.xfer(18);
    chk(word[17:0], wv(8));
    // each interface select bit low releases the output
    for (i = 0; i < 2; i++) begin
      ms0 = (i != 0);
      ms1 = (i != 1);
      repeat (6) @(negedge clk);
      chk(oe_n, 1'b1);
      ms0 = 1'b1;
      ms1 = 1'b1;
      repeat (6) @(negedge clk);
      chk(oe_n, 1'b0);
    end
    // clock enable low freezes a running conversion
    push(wv(9));
    conv(1'b0);
    ce = 1'b0;
    repeat (CC + 20) @(negedge clk);
    chk(busy, 1'b1);
    ce = 1'b1;
    wb(1'b0, CC + 20);
    repeat (2) @(negedge clk);
    i_host.xfer(18);
    chk(word[17:0], wv(9));
    end_sim();
  end
endmodule // asr_top_test
`default_nettype wire
